// ### src/efsr_defs.vh
// constants for the event flag and soft reset register bank
`ifndef EFSR_DEFS_VH
`define EFSR_DEFS_VH

// ****************************************
// register map
// ****************************************
`define EFSR_NUM_REGS      48
`define EFSR_ADDR_HUNDRED  6'h00
`define EFSR_ADDR_SECONDS  6'h01
`define EFSR_ADDR_MINUTES  6'h02
`define EFSR_ADDR_DAYS     6'h04
`define EFSR_ADDR_WEEKDAYS 6'h05
`define EFSR_ADDR_MONTHS   6'h06
`define EFSR_ADDR_ALM_LO   6'h08
`define EFSR_ADDR_ALM_HI   6'h0F
`define EFSR_ADDR_STAMP_LO 6'h11
`define EFSR_ADDR_STAMP_HI 6'h22
`define EFSR_ADDR_PIN_IO   6'h27
`define EFSR_ADDR_FUNCTION 6'h28
`define EFSR_ADDR_FLAGS    6'h2B
`define EFSR_ADDR_STOP_EN  6'h2E
`define EFSR_ADDR_RESET    6'h2F
`define EFSR_PTR_LAST      8'h2F

// ****************************************
// reset values
// ****************************************
`define EFSR_RST_SECONDS   8'h80
`define EFSR_RST_DAYS      8'h01
`define EFSR_RST_WEEKDAYS  8'h06
`define EFSR_RST_MONTHS    8'h01
`define EFSR_RST_ZERO      8'h00

// ****************************************
// fields and command codes
// ****************************************
`define EFSR_MIN_SUMMARY   7
`define EFSR_STOP_BIT      0
`define EFSR_CMD_SR        8'h2C
`define EFSR_CMD_PRE_CLR   8'hA4
`define EFSR_CMD_CTS       8'h25
`define EFSR_CMD_PRE_CTS   8'hA5

// ****************************************
// serial bus
// ****************************************
`define EFSR_SLAVE_ADDR    7'h51
`define EFSR_BITS_BYTE     4'h8

`endif

// ### src/efsr_cmd_decode.v
// command byte decoder for the soft reset command register
`timescale 1ns/10ps
`include "efsr_defs.vh"

module efsr_cmd_decode (
    // clock and reset
    input  wire       clk,
    input  wire       resetn,
    // command write
    input  wire       cmd_stb,
    input  wire [7:0] cmd_byte,
    // action pulses
    output reg        do_sr,
    output reg        do_pre_clr,
    output reg        do_cts
);

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            do_sr  <= 1'b0;
            do_pre_clr <= 1'b0;
            do_cts <= 1'b0;
        end else begin
            // unknown codes fall through with all pulses low
            do_sr  <= cmd_stb && (cmd_byte == `EFSR_CMD_SR);
            do_pre_clr <= cmd_stb && ((cmd_byte == `EFSR_CMD_PRE_CLR) ||
                                      (cmd_byte == `EFSR_CMD_PRE_CTS));
            do_cts <= cmd_stb && ((cmd_byte == `EFSR_CMD_CTS) ||
                                  (cmd_byte == `EFSR_CMD_PRE_CTS));
        end
    end

endmodule

// ### src/efsr_serial_slave.v
// two-wire serial slave: byte level write and read strobes
`timescale 1ns/10ps
`include "efsr_defs.vh"

module efsr_serial_slave (
    // clock and reset
    input  wire       clk,
    input  wire       resetn,
    // bus pins
    input  wire       scl_in,
    input  wire       sda_in,
    output reg        sda_oe_n,
    // byte side
    output reg        wr_stb,
    output reg        wr_ptr,
    output reg  [7:0] wr_data,
    output reg        rd_stb,
    input  wire [7:0] rd_data
);

    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_ADDR  = 3'h1;
    localparam [2:0] ST_WBYTE = 3'h2;
    localparam [2:0] ST_WACK  = 3'h3;
    localparam [2:0] ST_RBYTE = 3'h4;
    localparam [2:0] ST_RACK  = 3'h5;

    reg [2:0] state;
    reg [3:0] bitcnt;
    reg [7:0] shreg;
    reg       scl_q;
    reg       sda_q;
    reg       scl_r;
    reg       sda_r;
    reg       is_read;
    reg       first;
    reg       nack;

    wire start = scl_q && scl_r && sda_r && !sda_q;
    wire stop  = scl_q && scl_r && !sda_r && sda_q;
    wire rise  = scl_q && !scl_r;
    wire fall  = !scl_q && scl_r;
    wire full  = (bitcnt == `EFSR_BITS_BYTE);

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state    <= ST_IDLE;
            bitcnt   <= 4'h0;
            shreg    <= 8'h00;
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
            scl_r    <= 1'b1;
            sda_r    <= 1'b1;
            is_read  <= 1'b0;
            first    <= 1'b0;
            nack     <= 1'b0;
            sda_oe_n <= 1'b1;
            wr_stb   <= 1'b0;
            wr_ptr   <= 1'b0;
            wr_data  <= 8'h00;
            rd_stb   <= 1'b0;
        end else begin
            scl_q  <= scl_in;
            sda_q  <= sda_in;
            scl_r  <= scl_q;
            sda_r  <= sda_q;
            wr_stb <= 1'b0;
            rd_stb <= 1'b0;
            if (start) begin
                state    <= ST_ADDR;
                bitcnt   <= 4'h0;
                sda_oe_n <= 1'b1;
            end else if (stop) begin
                state    <= ST_IDLE;
                sda_oe_n <= 1'b1;
            end else begin
                case (state)
                    ST_ADDR, ST_WBYTE: begin
                        if (rise && !full) begin
                            shreg  <= {shreg[6:0], sda_q};
                            bitcnt <= bitcnt + 4'h1;
                        end else if (fall && full) begin
                            if (state == ST_ADDR && shreg[7:1] != `EFSR_SLAVE_ADDR) begin
                                state <= ST_IDLE;
                            end else begin
                                // out-of-range pointers still get acknowledged
                                sda_oe_n <= 1'b0;
                                state    <= ST_WACK;
                                if (state == ST_ADDR) begin
                                    is_read <= shreg[0];
                                    first   <= 1'b1;
                                end else begin
                                    wr_stb  <= 1'b1;
                                    wr_ptr  <= first;
                                    wr_data <= shreg;
                                    first   <= 1'b0;
                                end
                            end
                        end
                    end
                    ST_WACK, ST_RACK: begin
                        if (rise)
                            nack <= sda_q;
                        if (fall) begin
                            bitcnt <= 4'h1;
                            if (is_read && !(state == ST_RACK && nack)) begin
                                shreg    <= {rd_data[6:0], 1'b0};
                                sda_oe_n <= rd_data[7];
                                rd_stb   <= 1'b1;
                                state    <= ST_RBYTE;
                            end else if (is_read) begin
                                sda_oe_n <= 1'b1;
                                state    <= ST_IDLE;
                            end else begin
                                sda_oe_n <= 1'b1;
                                bitcnt   <= 4'h0;
                                state    <= ST_WBYTE;
                            end
                        end
                    end
                    ST_RBYTE: begin
                        if (fall) begin
                            bitcnt <= bitcnt + 4'h1;
                            if (full) begin
                                sda_oe_n <= 1'b1;
                                state    <= ST_RACK;
                            end else begin
                                sda_oe_n <= shreg[7];
                                shreg    <= {shreg[6:0], 1'b0};
                            end
                        end
                    end
                    default: begin
                        sda_oe_n <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule

// ### src/efsr_top.v
// event flag register and soft reset command bank of the clock device
//
// Behaviour
// - eight flags in one status byte, tick bit 7 down to capture one bit 0.
// - a flag is set by its event and stays until software clears it.
// - writing zero into a flag position clears that flag.
// - writing one into a flag position leaves that flag as it is.
// - a flag write stores current flags ANDed with the written byte.
// - all flags ORed into a summary bit read as minutes MSB.
// - command byte 2Ch to the command register starts a full soft reset.
// - soft reset also clears the prescaler and the timestamps.
// - command byte A4h clears only the prescaler.
// - command byte 25h clears the timestamps.
// - command byte A5h clears prescaler and timestamps together.
// - any other command byte is ignored without side effect.
// - power-on reset gives the soft reset state, but also zeroes the alarm registers 08h to 0Fh.
// - after reset calendar mode, no hundredths, 00:00:00.00, 2000.01.01, Saturday.
// - after reset interrupt A and clock pin give 32 kHz, capture pin off.
// - reset loads seconds 80h, days and months 01h, weekdays 06h, others zero.
// - soft reset leaves the alarm setting registers 08h to 0Fh unchanged.
// - stop gates the time base; prescaler clear resets the prescaler.
`timescale 1ns/10ps
`include "efsr_defs.vh"

module efsr_top (
    // clock and reset
    input  wire       clk,
    input  wire       resetn,
    // serial bus pins
    input  wire       scl_in,
    input  wire       sda_in,
    output reg        sda_out,
    output wire       sda_oe_n,
    // flag events from the owning functions, one bit per flag
    input  wire [7:0] flag_events,
    // stop request from the capture pin logic
    input  wire       capture_stop,
    // state towards the rest of the device
    output reg  [7:0] event_flags,
    output reg        event_summary,
    output reg        soft_reset_pulse,
    output reg        prescaler_clear,
    output reg        timestamp_clear,
    output reg        time_base_enable,
    output reg  [7:0] function_cfg,
    output reg  [7:0] pin_io_cfg
);

    // ****************************************
    // helpers
    // ****************************************
    function [7:0] efsr_reset_value;
        input [5:0] a;
        begin
            case (a)
                `EFSR_ADDR_SECONDS:  efsr_reset_value = `EFSR_RST_SECONDS;
                `EFSR_ADDR_DAYS:     efsr_reset_value = `EFSR_RST_DAYS;
                `EFSR_ADDR_WEEKDAYS: efsr_reset_value = `EFSR_RST_WEEKDAYS;
                `EFSR_ADDR_MONTHS:   efsr_reset_value = `EFSR_RST_MONTHS;
                default:             efsr_reset_value = `EFSR_RST_ZERO;
            endcase
        end
    endfunction

    function efsr_in_range;
        input [5:0] a;
        input [5:0] lo;
        input [5:0] hi;
        begin
            efsr_in_range = (a >= lo) && (a <= hi);
        end
    endfunction

    // ****************************************
    // storage and bus side
    // ****************************************
    reg  [7:0] regs [0:`EFSR_NUM_REGS-1];
    reg  [7:0] ptr;
    reg  [7:0] rd_data;
    reg  [7:0] next_flags;
    reg  [7:0] flag_mask;
    integer    i;

    wire       wr_stb;
    wire       wr_ptr;
    wire [7:0] wr_data;
    wire       rd_stb;
    wire       do_sr;
    wire       do_pre_clr;
    wire       do_cts;

    wire       ptr_ok   = (ptr <= `EFSR_PTR_LAST);
    wire       data_wr  = wr_stb && !wr_ptr && ptr_ok;
    wire       flag_wr  = data_wr && (ptr[5:0] == `EFSR_ADDR_FLAGS);
    wire       cmd_wr   = data_wr && (ptr[5:0] == `EFSR_ADDR_RESET);
    wire       plain_wr = data_wr && !flag_wr && !cmd_wr;

    efsr_serial_slave u_slave (
        .clk      (clk),
        .resetn   (resetn),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .sda_oe_n (sda_oe_n),
        .wr_stb   (wr_stb),
        .wr_ptr   (wr_ptr),
        .wr_data  (wr_data),
        .rd_stb   (rd_stb),
        .rd_data  (rd_data)
    );

    efsr_cmd_decode u_cmd (
        .clk      (clk),
        .resetn   (resetn),
        .cmd_stb  (cmd_wr),
        .cmd_byte (wr_data),
        .do_sr    (do_sr),
        .do_pre_clr (do_pre_clr),
        .do_cts   (do_cts)
    );

    // ****************************************
    // read data
    // ****************************************
    always @* begin
        if (!ptr_ok || ptr[5:0] == `EFSR_ADDR_RESET)
            rd_data = 8'h00;
        else if (ptr[5:0] == `EFSR_ADDR_FLAGS)
            rd_data = event_flags;
        else if (ptr[5:0] == `EFSR_ADDR_MINUTES)
            rd_data = {event_summary, regs[`EFSR_ADDR_MINUTES][6:0]};
        else
            rd_data = regs[ptr[5:0]];
    end

    // ****************************************
    // flag update
    // ****************************************
    always @* begin
        // soft reset zeroes the flags, a write ANDs, otherwise hold
        if (do_sr)
            flag_mask = 8'h00;
        else if (flag_wr)
            flag_mask = wr_data;
        else
            flag_mask = 8'hFF;
        // set beats clear so an event during the write is kept
        next_flags = (event_flags & flag_mask) | flag_events;
    end

    // ****************************************
    // registers
    // ****************************************
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // power-on gives the soft reset image; alarms start at zero here
            for (i = 0; i < `EFSR_NUM_REGS; i = i + 1) begin
                regs[i] <= efsr_reset_value(i[5:0]);
            end
            ptr              <= 8'h00;
            sda_out          <= 1'b0;
            event_flags      <= 8'h00;
            event_summary    <= 1'b0;
            soft_reset_pulse <= 1'b0;
            prescaler_clear  <= 1'b0;
            timestamp_clear  <= 1'b0;
            time_base_enable <= 1'b1;
            function_cfg     <= 8'h00;
            pin_io_cfg       <= 8'h00;
        end else begin
            sda_out <= 1'b0;
            // pointer: loaded by the first byte, bumped per data byte, wraps
            if (wr_stb && wr_ptr) begin
                ptr <= wr_data;
            end else if ((data_wr || rd_stb) && ptr_ok) begin
                if (ptr == `EFSR_PTR_LAST)
                    ptr <= 8'h00;
                else
                    ptr <= ptr + 8'h01;
            end

            if (do_sr) begin
                for (i = 0; i < `EFSR_NUM_REGS; i = i + 1) begin
                    if (!efsr_in_range(i[5:0], `EFSR_ADDR_ALM_LO, `EFSR_ADDR_ALM_HI))
                        regs[i] <= efsr_reset_value(i[5:0]);
                end
            end else begin
                if (do_cts) begin
                    for (i = 0; i < `EFSR_NUM_REGS; i = i + 1) begin
                        if (efsr_in_range(i[5:0], `EFSR_ADDR_STAMP_LO, `EFSR_ADDR_STAMP_HI))
                            regs[i] <= `EFSR_RST_ZERO;
                    end
                end
                // command decode runs a cycle behind, so no clash with a write
                if (plain_wr)
                    regs[ptr[5:0]] <= wr_data;
            end

            event_flags   <= next_flags;
            event_summary <= |next_flags;

            soft_reset_pulse <= do_sr;
            prescaler_clear  <= do_sr || do_pre_clr;
            timestamp_clear  <= do_sr || do_cts;

            // stop freezes the time base; output clocks are not touched here
            time_base_enable <= !(regs[`EFSR_ADDR_STOP_EN][`EFSR_STOP_BIT] ||
                                  capture_stop);
            // zero in both means 32 kHz on both outputs and capture pin off
            function_cfg     <= regs[`EFSR_ADDR_FUNCTION];
            pin_io_cfg       <= regs[`EFSR_ADDR_PIN_IO];
        end
    end

endmodule

// ### testbench/efsr_top_asserts.sv
// port-level checks for the event flag and soft reset bank
`timescale 1ns/10ps
module efsr_top_asserts (
    // clock and reset
    input wire       clk,
    input wire       resetn,
    // bus pins
    input wire       scl_in,
    input wire       sda_in,
    input wire       sda_out,
    input wire       sda_oe_n,
    // device side
    input wire [7:0] flag_events,
    input wire       capture_stop,
    input wire [7:0] event_flags,
    input wire       event_summary,
    input wire       soft_reset_pulse,
    input wire       prescaler_clear,
    input wire       timestamp_clear,
    input wire       time_base_enable,
    input wire [7:0] function_cfg,
    input wire [7:0] pin_io_cfg
);
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    chk_summary_or: assert property (event_summary == (|event_flags))
        else $error("summary bit differs from OR of flags");
    chk_event_sets: assert property ((|flag_events) |=>
        ((event_flags & $past(flag_events)) == $past(flag_events)))
        else $error("event did not set its flag");
    // a flag may only drop during a bus write ack or a soft reset
    chk_flag_hold: assert property (((~event_flags & $past(event_flags)) != 8'h00)
        |-> ##[0:2] (!sda_oe_n || soft_reset_pulse))
        else $error("flag cleared without a write");
    chk_sr_single: assert property (soft_reset_pulse |=> !soft_reset_pulse)
        else $error("soft reset pulse longer than one cycle");
    chk_sr_actions: assert property (soft_reset_pulse |-> prescaler_clear && timestamp_clear)
        else $error("soft reset without both clear actions");
    chk_pc_single: assert property (prescaler_clear |=> !prescaler_clear)
        else $error("prescaler clear longer than one cycle");
    chk_ts_single: assert property ($rose(timestamp_clear) |=> !timestamp_clear)
        else $error("timestamp clear longer than one cycle");
    chk_sr_flags: assert property (soft_reset_pulse && $past(flag_events) == 8'h00
        && $past(flag_events, 2) == 8'h00 |-> event_flags == 8'h00)
        else $error("flags not cleared by soft reset");
    chk_stop_gates: assert property (capture_stop |=> !time_base_enable)
        else $error("time base runs while stopped");
endmodule

bind efsr_top efsr_top_asserts efsr_top_asserts_inst (
    .clk(clk), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .flag_events(flag_events),
    .capture_stop(capture_stop), .event_flags(event_flags),
    .event_summary(event_summary), .soft_reset_pulse(soft_reset_pulse),
    .prescaler_clear(prescaler_clear), .timestamp_clear(timestamp_clear),
    .time_base_enable(time_base_enable), .function_cfg(function_cfg),
    .pin_io_cfg(pin_io_cfg)
);

// ### testbench/efsr_top_test.sv
// self-checking bench for the event flag and soft reset bank
`timescale 1ns/10ps
module efsr_top_test;
    // command codes and expected {reset, prescaler, timestamp} pulses
    localparam [55:0] CMD_CODES = 56'h2CA425A5002DFF;
    localparam [20:0] CMD_ACTS  = 21'h1D1600;
    // bus runs about 17k cycles, so this leaves ample slack
    localparam integer LIMIT = 50000;
    reg        clk;
    reg        resetn;
    reg        scl;
    reg        sda_m;
    reg  [7:0] flag_events;
    reg        capture_stop;
    wire       sda_out;
    wire       sda_oe_n;
    wire       sda_in;
    wire [7:0] event_flags;
    wire       event_summary;
    wire       soft_reset_pulse;
    wire       prescaler_clear;
    wire       timestamp_clear;
    wire       time_base_enable;
    wire [7:0] function_cfg;
    wire [7:0] pin_io_cfg;
    integer    error_cnt = 0;
    integer    compares = 0;
    integer    cycles = 0;
    integer    n_sr = 0;
    integer    n_pc = 0;
    integer    n_ts = 0;

    // open-drain line with pull-up
    assign sda_in = sda_m & sda_oe_n;

    efsr_top efsr_top_inst (
        .clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda_in), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .flag_events(flag_events), .capture_stop(capture_stop),
        .event_flags(event_flags), .event_summary(event_summary),
        .soft_reset_pulse(soft_reset_pulse), .prescaler_clear(prescaler_clear),
        .timestamp_clear(timestamp_clear), .time_base_enable(time_base_enable),
        .function_cfg(function_cfg), .pin_io_cfg(pin_io_cfg)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (soft_reset_pulse === 1'b1) n_sr <= n_sr + 1;
        if (prescaler_clear === 1'b1) n_pc <= n_pc + 1;
        if (timestamp_clear === 1'b1) n_ts <= n_ts + 1;
        if (cycles == LIMIT) begin
            error_cnt = error_cnt + 1;
            tally_and_finish;
        end
    end

    // ****************
    // helpers
    // ****************
    task tick(input integer n);
        repeat (n) @(negedge clk);
    endtask

    task cmp8(input string what, input [7:0] exp, input [7:0] got);
        compares = compares + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("ERROR %0s expected %h seen %h", what, exp, got);
        end
    endtask

    task bus_bit(input b, output r);
        sda_m = b;
        tick(5);
        scl = 1'b1;
        tick(5);
        r = sda_in;
        scl = 1'b0;
        tick(1);
    endtask

    task bus_byte(input [7:0] d, input mack, output [7:0] q, output ack);
        integer i;
        for (i = 7; i >= 0; i = i - 1) bus_bit(d[i], q[i]);
        bus_bit(mack, ack);
    endtask

    task bus_start;
        sda_m = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(5);
        sda_m = 1'b0;
        tick(5);
        scl = 1'b0;
        tick(1);
    endtask

    task bus_stop;
        sda_m = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(5);
        sda_m = 1'b1;
        tick(5);
    endtask

    task wr_reg(input [7:0] ptr, input [7:0] d);
        reg [7:0] q;
        reg       a;
        bus_start;
        bus_byte(8'hA2, 1'b1, q, a);
        bus_byte(ptr, 1'b1, q, a);
        bus_byte(d, 1'b1, q, a);
        cmp8("data ack", 8'h00, {7'h00, a});
        bus_stop;
    endtask

    task chk_reg(input string what, input [7:0] ptr, input [7:0] exp);
        reg [7:0] q;
        reg       a;
        bus_start;
        bus_byte(8'hA2, 1'b1, q, a);
        bus_byte(ptr, 1'b1, q, a);
        bus_start;
        bus_byte(8'hA3, 1'b1, q, a);
        bus_byte(8'hFF, 1'b1, q, a);
        bus_stop;
        cmp8(what, exp, q);
    endtask

    task pulse_events(input [7:0] ev);
        flag_events = ev;
        tick(1);
        flag_events = 8'h00;
        tick(2);
    endtask

    // ****************
    // scenarios
    // ****************
    task test_reset_values;
        chk_reg("seconds", 8'h01, 8'h80);
        chk_reg("minutes", 8'h02, 8'h00);
        chk_reg("days", 8'h04, 8'h01);
        chk_reg("weekdays", 8'h05, 8'h06);
        chk_reg("months", 8'h06, 8'h01);
        chk_reg("function", 8'h28, 8'h00);
        chk_reg("flags", 8'h2B, 8'h00);
        chk_reg("command read", 8'h2F, 8'h00);
    endtask

    task test_flags;
        pulse_events(8'h10);
        chk_reg("watchdog position", 8'h2B, 8'h10);
        pulse_events(8'hFF);
        cmp8("flag port", 8'hFF, event_flags);
        chk_reg("minutes summary", 8'h02, 8'h80);
        wr_reg(8'h2B, 8'hA5);
        cmp8("and write", 8'hA5, event_flags);
        wr_reg(8'h2B, 8'h0F);
        chk_reg("ones keep", 8'h2B, 8'h05);
        wr_reg(8'h2B, 8'h00);
        cmp8("zeros clear", 8'h00, event_flags);
        cmp8("summary off", 8'h00, {7'h00, event_summary});
    endtask

    task test_commands;
        integer   i;
        reg [2:0] act;
        for (i = 0; i < 7; i = i + 1) begin
            n_sr = 0;
            n_pc = 0;
            n_ts = 0;
            wr_reg(8'h2F, CMD_CODES[55-8*i -: 8]);
            tick(4);
            act = CMD_ACTS[20-3*i -: 3];
            cmp8("reset pulses", {7'h00, act[2]}, n_sr[7:0]);
            cmp8("prescaler pulses", {7'h00, act[1]}, n_pc[7:0]);
            cmp8("timestamp pulses", {7'h00, act[0]}, n_ts[7:0]);
        end
    endtask

    task test_clear_effects;
        wr_reg(8'h11, 8'h5A);
        wr_reg(8'h22, 8'h5A);
        wr_reg(8'h08, 8'h5A);
        wr_reg(8'h01, 8'h33);
        wr_reg(8'h2F, 8'hA4);
        chk_reg("stamp kept by pre clear", 8'h11, 8'h5A);
        wr_reg(8'h2F, 8'h25);
        chk_reg("stamp first", 8'h11, 8'h00);
        chk_reg("stamp last", 8'h22, 8'h00);
        chk_reg("seconds kept", 8'h01, 8'h33);
        wr_reg(8'h11, 8'h5A);
        pulse_events(8'h04);
        wr_reg(8'h2F, 8'h2C);
        chk_reg("stamp after reset", 8'h11, 8'h00);
        chk_reg("alarm kept", 8'h08, 8'h5A);
        chk_reg("seconds reset", 8'h01, 8'h80);
        chk_reg("flags reset", 8'h2B, 8'h00);
        // dirty seconds, function, pin io and flags first, so their power-on checks can fail
        wr_reg(8'h01, 8'h33);
        wr_reg(8'h28, 8'h3C);
        cmp8("function port", 8'h3C, function_cfg);
        wr_reg(8'h27, 8'h5A);
        cmp8("pin io port", 8'h5A, pin_io_cfg);
        pulse_events(8'h81);
        resetn = 1'b0;
        tick(2);
        resetn = 1'b1;
        tick(3);
        cmp8("flags power on", 8'h00, event_flags);
        cmp8("function power on", 8'h00, function_cfg);
        cmp8("pin io power on", 8'h00, pin_io_cfg);
        cmp8("sda out", 8'h00, {7'h00, sda_out});
        chk_reg("seconds power on", 8'h01, 8'h80);
        chk_reg("days power on", 8'h04, 8'h01);
    endtask

    task test_stop;
        capture_stop = 1'b1;
        tick(3);
        cmp8("stop pin", 8'h00, {7'h00, time_base_enable});
        capture_stop = 1'b0;
        tick(3);
        cmp8("run again", 8'h01, {7'h00, time_base_enable});
        wr_reg(8'h2E, 8'h01);
        tick(2);
        cmp8("stop bit", 8'h00, {7'h00, time_base_enable});
        wr_reg(8'h2F, 8'hA4);
        cmp8("stop kept by pre clear", 8'h00, {7'h00, time_base_enable});
        wr_reg(8'h2E, 8'h00);
        tick(2);
        cmp8("stop bit off", 8'h01, {7'h00, time_base_enable});
    endtask

    task tally_and_finish;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        resetn = 1'b0;
        scl = 1'b1;
        sda_m = 1'b1;
        flag_events = 8'h00;
        capture_stop = 1'b0;
        tick(16);
        resetn = 1'b1;
        tick(4);
        test_reset_values;
        test_flags;
        test_commands;
        test_clear_effects;
        test_stop;
        tally_and_finish;
    end
endmodule
